// ---- src/ctb_pkg.sv ----
/*
 * Constants for the per-channel transmit buffer block: register map,
 * field positions, reset values, result codes and engine states.
 * Assumes a 32-bit APB slave port and a protocol engine on the same clock.
 */
// Notes on behaviour
// - single-attempt frame goes out once; no retry after arbitration loss or error
// - single-attempt success gives result 10, or 11 with abort pending
// - single-attempt arbitration loss or bus error ends request with result 01
// - history label used only with both history enables and store flag set
// - buffer done-interrupt enable raises channel transmit interrupt on completion
// - channel abort-done enable raises channel transmit interrupt on abort completion
// - result 11 raises the completion interrupt, never the abort interrupt
// - abort completion sets result 01 and clears request pending
// - each channel holds sixty-four transmit buffers
package ctb_pkg;
  // ---------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------
  localparam int NBUF = 64;
  localparam int IDXW = 6;
  localparam int AW   = 12;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFS_CTL    = 12'h000;
  localparam logic [11:0] OFS_STS    = 12'h100;
  localparam logic [11:0] OFS_MSG    = 12'h400;
  localparam logic [11:0] OFS_IEN_LO = 12'h800;
  localparam logic [11:0] OFS_IEN_HI = 12'h804;
  localparam logic [11:0] OFS_CHCTL  = 12'h808;
  localparam logic [11:0] OFS_HIST   = 12'h80C;
  localparam logic [11:0] SPAN_CTL   = 12'h100;
  localparam logic [11:0] SPAN_MSG   = 12'h400;

  // message words inside one buffer
  localparam logic [1:0] MSG_ID  = 2'h0;
  localparam logic [1:0] MSG_PTR = 2'h1;
  localparam logic [1:0] MSG_D0  = 2'h2;
  localparam logic [1:0] MSG_D1  = 2'h3;

  // ---------------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------------
  localparam int CTL_TR    = 0;
  localparam int CTL_AR    = 1;
  localparam int CTL_SA    = 2;
  localparam int STS_PEND  = 2;
  localparam int CH_ABORT_DONE_IRQ_ENABLE   = 0;
  localparam int HIST_EN   = 0;
  localparam int HIST_DED  = 1;
  localparam int ID_HFLAG  = 29;
  localparam int IDW       = 29;

  // ---------------------------------------------------------------------
  // result codes and reset values
  // ---------------------------------------------------------------------
  localparam logic [1:0] RES_IDLE  = 2'h0;
  localparam logic [1:0] RES_ABORT = 2'h1;
  localparam logic [1:0] RES_DONE  = 2'h2;
  localparam logic [1:0] RES_DONAB = 2'h3;
  localparam logic [2:0] CTL_RST   = 3'h0;
  localparam logic [1:0] HIST_RST  = 2'h0;

  typedef enum logic {ST_IDLE, ST_BUSY} ctb_state_t;
endpackage : ctb_pkg

// ---- src/ctb_sel_if.sv ----
/*
 * Request vector and pick result between the buffer logic and its
 * priority picker. Assumes both ends share one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
interface ctb_sel_if #(parameter int N = 64);
  logic [N-1:0]         req;
  logic                 found;
  logic [$clog2(N)-1:0] idx;
  modport owner  (output req, input found, input idx);
  modport picker (input req, output found, output idx);
endinterface : ctb_sel_if
`default_nettype wire

// ---- src/ctb_select.sv ----
/*
 * Lowest-number-first picker over a request vector.
 * Assumes the request vector is stable within the cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module ctb_select #(
  parameter int N = 64
) (
  // request and pick
  ctb_sel_if.picker sel
);
  localparam int IW = $clog2(N);

  always_comb begin
    sel.found = |sel.req;
    sel.idx   = '0;
    // walk downward so the lowest number is the last to land
    for (int i = N - 1; i >= 0; i--) begin
      if (sel.req[i]) begin
        sel.idx = IW'(i);
      end
    end
  end
endmodule : ctb_select
`default_nettype wire

// ---- src/ctb_top.sv ----
/*
 * Transmit buffers of one channel: APB register file, buffer pick,
 * single-attempt handling, result codes, history hand-off and the
 * channel transmit interrupt pulse.
 * Assumes a bit-level engine on pclk reporting one outcome per frame.
 */
`timescale 1ns/1ns
`default_nettype none
module ctb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // frame to the protocol engine
  output logic             frame_start,
  output logic      [5:0]  frame_buf,
  output logic      [28:0] frame_id,
  output logic      [31:0] frame_data0,
  output logic      [31:0] frame_data1,
  output logic             frame_single,
  // outcome from the protocol engine
  input  wire logic        link_ok,
  input  wire logic        link_arb_lost,
  input  wire logic        link_bus_error,
  // history hand-off
  output logic             hist_store,
  output logic      [5:0]  hist_buf,
  output logic      [31:0] hist_label,
  // interrupt
  output logic             channel_tx_interrupt
);
  localparam int N = ctb_pkg::NBUF;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  ctb_pkg::ctb_state_t    st_reg, st_next;
  logic [5:0]             cur_reg, cur_next;
  logic [N-1:0][2:0]      ctl_reg, ctl_next;
  logic [N-1:0][1:0]      res_reg, res_next;
  logic [N-1:0]           pend_reg, pend_next;
  logic [63:0]            ien_reg, ien_next;
  logic                   abort_done_irq_enable_reg, abort_done_irq_enable_next;
  logic [1:0]             hcfg_reg, hcfg_next;
  logic [31:0]            prdata_reg, prdata_next;
  logic                   pready_reg, pready_next;
  logic                   perr_reg, perr_next;
  logic                   start_reg, start_next;
  logic [5:0]             fbuf_reg, fbuf_next;
  logic [28:0]            fid_reg, fid_next;
  logic [31:0]            fd0_reg, fd0_next;
  logic [31:0]            fd1_reg, fd1_next;
  logic                   fsa_reg, fsa_next;
  logic                   hst_reg, hst_next;
  logic [5:0]             hbuf_reg, hbuf_next;
  logic [31:0]            hlab_reg, hlab_next;
  logic                   irq_reg, irq_next;
  logic [31:0]            msg_mem [4*N];
  logic                   done_evt, abort_evt, fail_evt;
  logic                   wr_fire, rd_take;

  ctb_sel_if #(.N(N)) tx_sel ();
  ctb_sel_if #(.N(N)) ab_sel ();

  ctb_select #(.N(N)) u_tx_pick (.sel(tx_sel));
  ctb_select #(.N(N)) u_ab_pick (.sel(ab_sel));

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] base,
                               input logic [11:0] span);
    hit = (a >= base) && (a < base + span) && (a[1:0] == 2'h0);
  endfunction : hit

  // ---------------------------------------------------------------------
  // pick vectors
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N; i++) begin
      tx_sel.req[i] = pend_reg[i] && !ctl_reg[i][ctb_pkg::CTL_AR] &&
                      (st_reg == ctb_pkg::ST_IDLE);
      // the buffer on the wire finishes through the engine, not here
      ab_sel.req[i] = pend_reg[i] && ctl_reg[i][ctb_pkg::CTL_AR] &&
                      !((st_reg == ctb_pkg::ST_BUSY) && (cur_reg == 6'(i)));
    end
  end

  assign rd_take = psel && penable && !pready_reg;
  assign wr_fire = psel && penable && pready_reg && pwrite;
  assign fail_evt = link_arb_lost || link_bus_error;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    cur_next  = cur_reg;
    ctl_next  = ctl_reg;
    res_next  = res_reg;
    pend_next = pend_reg;
    ien_next  = ien_reg;
    abort_done_irq_enable_next = abort_done_irq_enable_reg;
    hcfg_next = hcfg_reg;
    start_next = 1'b0;
    fbuf_next = fbuf_reg;
    fid_next  = fid_reg;
    fd0_next  = fd0_reg;
    fd1_next  = fd1_reg;
    fsa_next  = fsa_reg;
    hst_next  = 1'b0;
    hbuf_next = hbuf_reg;
    hlab_next = hlab_reg;
    done_evt  = 1'b0;
    abort_evt = 1'b0;
    pready_next = rd_take;
    perr_next   = 1'b0;
    prdata_next = 32'h0000_0000;

    // read side, answered one cycle into the access phase
    if (rd_take && !pwrite) begin
      if (hit(paddr, ctb_pkg::OFS_CTL, ctb_pkg::SPAN_CTL)) begin
        prdata_next[2:0] = ctl_reg[paddr[7:2]];
      end else if (hit(paddr, ctb_pkg::OFS_STS, ctb_pkg::SPAN_CTL)) begin
        prdata_next[1:0] = res_reg[paddr[7:2]];
        prdata_next[ctb_pkg::STS_PEND] = pend_reg[paddr[7:2]];
      end else if (hit(paddr, ctb_pkg::OFS_MSG, ctb_pkg::SPAN_MSG)) begin
        prdata_next = msg_mem[paddr[9:2]];
      end else if (paddr == ctb_pkg::OFS_IEN_LO) begin
        prdata_next = ien_reg[31:0];
      end else if (paddr == ctb_pkg::OFS_IEN_HI) begin
        prdata_next = ien_reg[63:32];
      end else if (paddr == ctb_pkg::OFS_CHCTL) begin
        prdata_next[ctb_pkg::CH_ABORT_DONE_IRQ_ENABLE] = abort_done_irq_enable_reg;
      end else if (paddr == ctb_pkg::OFS_HIST) begin
        prdata_next[1:0] = hcfg_reg;
      end else begin
        perr_next = 1'b1;
      end
    end

    // software writes first, so hardware outcomes below win the cycle
    if (wr_fire) begin
      if (hit(paddr, ctb_pkg::OFS_CTL, ctb_pkg::SPAN_CTL)) begin
        ctl_next[paddr[7:2]] = pwdata[2:0];
        if (pwdata[ctb_pkg::CTL_TR]) begin
          pend_next[paddr[7:2]] = 1'b1;
        end
      end else if (hit(paddr, ctb_pkg::OFS_STS, ctb_pkg::SPAN_CTL)) begin
        // a clear is honoured only once the buffer has let go
        if (pwdata[1:0] == ctb_pkg::RES_IDLE && !pend_reg[paddr[7:2]]) begin
          res_next[paddr[7:2]] = ctb_pkg::RES_IDLE;
          ctl_next[paddr[7:2]] = ctb_pkg::CTL_RST;
        end
      end else if (paddr == ctb_pkg::OFS_IEN_LO) begin
        ien_next[31:0] = pwdata;
      end else if (paddr == ctb_pkg::OFS_IEN_HI) begin
        ien_next[63:32] = pwdata;
      end else if (paddr == ctb_pkg::OFS_CHCTL) begin
        abort_done_irq_enable_next = pwdata[ctb_pkg::CH_ABORT_DONE_IRQ_ENABLE];
      end else if (paddr == ctb_pkg::OFS_HIST) begin
        hcfg_next = pwdata[1:0];
      end
    end

    // abort of a buffer that is not on the wire completes at once
    if (ab_sel.found) begin
      res_next[ab_sel.idx]  = ctb_pkg::RES_ABORT;
      pend_next[ab_sel.idx] = 1'b0;
      ctl_next[ab_sel.idx][ctb_pkg::CTL_TR] = 1'b0;
      ctl_next[ab_sel.idx][ctb_pkg::CTL_AR] = 1'b0;
      abort_evt = 1'b1;
    end

    case (st_reg)
      ctb_pkg::ST_IDLE: begin
        if (tx_sel.found) begin
          st_next    = ctb_pkg::ST_BUSY;
          cur_next   = tx_sel.idx;
          start_next = 1'b1;
          fbuf_next  = tx_sel.idx;
          fid_next   = msg_mem[{tx_sel.idx, ctb_pkg::MSG_ID}][28:0];
          fd0_next   = msg_mem[{tx_sel.idx, ctb_pkg::MSG_D0}];
          fd1_next   = msg_mem[{tx_sel.idx, ctb_pkg::MSG_D1}];
          fsa_next   = ctl_reg[tx_sel.idx][ctb_pkg::CTL_SA];
        end
      end
      ctb_pkg::ST_BUSY: begin
        if (link_ok) begin
          st_next = ctb_pkg::ST_IDLE;
          res_next[cur_reg] = ctl_reg[cur_reg][ctb_pkg::CTL_AR] ?
                              ctb_pkg::RES_DONAB : ctb_pkg::RES_DONE;
          pend_next[cur_reg] = 1'b0;
          ctl_next[cur_reg][ctb_pkg::CTL_TR] = 1'b0;
          ctl_next[cur_reg][ctb_pkg::CTL_AR] = 1'b0;
          done_evt = 1'b1;
          hst_next = hcfg_reg[ctb_pkg::HIST_EN] &&
                     hcfg_reg[ctb_pkg::HIST_DED] &&
                     msg_mem[{cur_reg, ctb_pkg::MSG_ID}][ctb_pkg::ID_HFLAG];
          hbuf_next = cur_reg;
          hlab_next = msg_mem[{cur_reg, ctb_pkg::MSG_PTR}];
        end else if (fail_evt) begin
          st_next = ctb_pkg::ST_IDLE;
          // a normal request simply stays pending and is picked again
          if (ctl_reg[cur_reg][ctb_pkg::CTL_SA] ||
              ctl_reg[cur_reg][ctb_pkg::CTL_AR]) begin
            res_next[cur_reg]  = ctb_pkg::RES_ABORT;
            pend_next[cur_reg] = 1'b0;
            ctl_next[cur_reg][ctb_pkg::CTL_TR] = 1'b0;
            ctl_next[cur_reg][ctb_pkg::CTL_AR] = 1'b0;
            abort_evt = 1'b1;
          end
        end
      end
      default: st_next = ctb_pkg::ST_IDLE;
    endcase

    irq_next = (done_evt && ien_reg[cur_reg]) ||
               (abort_evt && abort_done_irq_enable_reg);
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg     <= ctb_pkg::ST_IDLE;
      cur_reg    <= 6'h00;
      ctl_reg    <= '0;
      res_reg    <= '0;
      pend_reg   <= '0;
      ien_reg    <= 64'h0000_0000_0000_0000;
      abort_done_irq_enable_reg   <= 1'b0;
      hcfg_reg   <= ctb_pkg::HIST_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
      start_reg  <= 1'b0;
      fbuf_reg   <= 6'h00;
      fid_reg    <= 29'h0000_0000;
      fd0_reg    <= 32'h0000_0000;
      fd1_reg    <= 32'h0000_0000;
      fsa_reg    <= 1'b0;
      hst_reg    <= 1'b0;
      hbuf_reg   <= 6'h00;
      hlab_reg   <= 32'h0000_0000;
      irq_reg    <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cur_reg    <= cur_next;
      ctl_reg    <= ctl_next;
      res_reg    <= res_next;
      pend_reg   <= pend_next;
      ien_reg    <= ien_next;
      abort_done_irq_enable_reg   <= abort_done_irq_enable_next;
      hcfg_reg   <= hcfg_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      perr_reg   <= perr_next;
      start_reg  <= start_next;
      fbuf_reg   <= fbuf_next;
      fid_reg    <= fid_next;
      fd0_reg    <= fd0_next;
      fd1_reg    <= fd1_next;
      fsa_reg    <= fsa_next;
      hst_reg    <= hst_next;
      hbuf_reg   <= hbuf_next;
      hlab_reg   <= hlab_next;
      irq_reg    <= irq_next;
    end
  end

  // message words carry no reset; software loads them before a request
  always_ff @(posedge pclk) begin
    if (wr_fire && hit(paddr, ctb_pkg::OFS_MSG, ctb_pkg::SPAN_MSG)) begin
      msg_mem[paddr[9:2]] <= pwdata;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = perr_reg;
  assign frame_start  = start_reg;
  assign frame_buf    = fbuf_reg;
  assign frame_id     = fid_reg;
  assign frame_data0  = fd0_reg;
  assign frame_data1  = fd1_reg;
  assign frame_single = fsa_reg;
  assign hist_store   = hst_reg;
  assign hist_buf     = hbuf_reg;
  assign hist_label   = hlab_reg;
  assign channel_tx_interrupt = irq_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_busy_fail;
    st_reg == ctb_pkg::ST_BUSY && fail_evt && !link_ok;
  endsequence
  sequence s_busy_ok;
    st_reg == ctb_pkg::ST_BUSY && link_ok;
  endsequence

  AST_SINGLE_NO_RETRY: assert property (
    s_busy_fail and (ctl_reg[cur_reg][ctb_pkg::CTL_SA]) |=>
      !pend_reg[$past(cur_reg)] ##1
      (!start_reg || frame_buf != $past(cur_reg, 2)))
    else $error("single-attempt buffer retried");
  AST_SINGLE_FAIL_RES: assert property (
    s_busy_fail and (ctl_reg[cur_reg][ctb_pkg::CTL_SA]) |=>
      res_reg[$past(cur_reg)] == ctb_pkg::RES_ABORT)
    else $error("failed single attempt not reported as aborted");
  AST_DONE_CODE: assert property (
    s_busy_ok |=> res_reg[$past(cur_reg)] ==
      ($past(ctl_reg[cur_reg][ctb_pkg::CTL_AR]) ?
       ctb_pkg::RES_DONAB : ctb_pkg::RES_DONE))
    else $error("wrong completion code");
  AST_ABORT_COMPLETE: assert property (
    ab_sel.found |=> res_reg[$past(ab_sel.idx)] == ctb_pkg::RES_ABORT &&
      !pend_reg[$past(ab_sel.idx)])
    else $error("abort did not complete");
  AST_PEND_RELEASED: assert property (
    s_busy_ok |=> !pend_reg[$past(cur_reg)] && st_reg == ctb_pkg::ST_IDLE)
    else $error("pending not cleared after completion");
  AST_DONE_IRQ: assert property (
    s_busy_ok and (ien_reg[cur_reg]) |=> channel_tx_interrupt)
    else $error("completion interrupt missing");
  AST_ABORT_IRQ: assert property (
    ab_sel.found && abort_done_irq_enable_reg |=> channel_tx_interrupt)
    else $error("abort interrupt missing");
  AST_ABRQ_NO_ABORT_IRQ: assert property (
    s_busy_ok and (ctl_reg[cur_reg][ctb_pkg::CTL_AR] &&
      !ien_reg[cur_reg] && !ab_sel.found) |=> !channel_tx_interrupt)
    else $error("abort interrupt on completion with abort request");
  AST_HIST_GATE: assert property (
    hist_store |-> $past(hcfg_reg) == 2'h3 &&
      $past(st_reg) == ctb_pkg::ST_BUSY && $past(link_ok))
    else $error("history store without enables");
  AST_CLEAR_IDLE: assert property (
    wr_fire && hit(paddr, ctb_pkg::OFS_STS, ctb_pkg::SPAN_CTL) &&
      pwdata[1:0] == ctb_pkg::RES_IDLE && !pend_reg[paddr[7:2]] |=>
      res_reg[$past(paddr[7:2])] == ctb_pkg::RES_IDLE &&
      ctl_reg[$past(paddr[7:2])] == ctb_pkg::CTL_RST)
    else $error("result clear did not return buffer to idle");
endmodule : ctb_top
`default_nettype wire

// ---- sim/ctb_link_model.sv ----
/*
 * Stand-in for the protocol engine and the other bus nodes: one outcome
 * per frame after a chosen delay. Assumes pclk and presetn of the block.
 */
`timescale 1ns/1ns
`default_nettype none
module ctb_link_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // frame and test control
  input  wire logic       frame_start,
  input  wire logic [1:0] mode,
  input  wire logic [4:0] dly,
  // outcome pulses
  output logic            link_ok,
  output logic            link_arb_lost,
  output logic            link_bus_error
);
  logic       busy;
  logic       failed;
  logic [4:0] cnt;

  // mode 3 loses arbitration once, then succeeds on the resend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy           <= 1'b0;
      failed         <= 1'b0;
      cnt            <= 5'h0;
      link_ok        <= 1'b0;
      link_arb_lost  <= 1'b0;
      link_bus_error <= 1'b0;
    end else begin
      link_ok        <= 1'b0;
      link_arb_lost  <= 1'b0;
      link_bus_error <= 1'b0;
      if (frame_start) begin
        busy <= 1'b1;
        cnt  <= dly;
      end else if (busy && cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
      end else if (busy) begin
        busy <= 1'b0;
        case (mode)
          2'h0: link_ok <= 1'b1;
          2'h1: link_arb_lost <= 1'b1;
          2'h2: link_bus_error <= 1'b1;
          default: begin
            link_ok       <= failed;
            link_arb_lost <= !failed;
            failed        <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule : ctb_link_model
`default_nettype wire

// ---- sim/tb.sv ----
/*
 * Self-checking bench for the transmit buffer block: APB master,
 * read-result queue, outcome model and pulse counters.
 * Assumes the block answers every APB access with pready.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, frame_data0, frame_data1, hist_label;
  logic        frame_start, frame_single, hist_store, channel_tx_interrupt;
  logic [5:0]  frame_buf, hist_buf;
  logic [28:0] frame_id, last_id;
  logic        link_ok, link_arb_lost, link_bus_error;
  logic [1:0]  mode;
  logic [4:0]  dly;
  logic [31:0] lfsr_q, id_w, lbl_w, last_lbl;
  logic [32:0] expq[$];
  logic [32:0] e;
  int          mismatches, samples_checked, cycles, n_frm, n_irq, n_hist;

  ctb_top ctb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .frame_buf(frame_buf), .frame_id(frame_id),
    .frame_data0(frame_data0), .frame_data1(frame_data1),
    .frame_single(frame_single), .link_ok(link_ok),
    .link_arb_lost(link_arb_lost), .link_bus_error(link_bus_error),
    .hist_store(hist_store), .hist_buf(hist_buf), .hist_label(hist_label),
    .channel_tx_interrupt(channel_tx_interrupt));
  ctb_link_model ctb_link_model_i (.pclk(pclk), .presetn(presetn),
    .frame_start(frame_start), .mode(mode), .dly(dly), .link_ok(link_ok),
    .link_arb_lost(link_arb_lost), .link_bus_error(link_bus_error));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [11:0] ca(input int b);
    return ctb_pkg::OFS_CTL + 12'(4 * b);
  endfunction : ca
  function automatic logic [11:0] sa(input int b);
    return ctb_pkg::OFS_STS + 12'(4 * b);
  endfunction : sa

  task automatic stop_test();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    expq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic load(input int b, input logic flag);
    logic [11:0] base;
    base   = ctb_pkg::OFS_MSG + 12'(16 * b);
    lfsr_q = lfsr(lfsr_q);
    id_w   = {2'h0, flag, lfsr_q[28:0]};
    lbl_w  = lfsr(lfsr_q);
    lfsr_q = lfsr(lbl_w);
    apb(1'b1, base, id_w);
    apb(1'b1, base + 12'h4, lbl_w);
    apb(1'b1, base + 12'h8, lfsr_q);
    apb(1'b1, base + 12'hC, ~lfsr_q);
  endtask : load
  task automatic run(input int b, input logic [31:0] c,
                     input logic [1:0] m, input logic [4:0] d);
    mode <= m;
    dly  <= d;
    apb(1'b1, ca(b), c);
    repeat (2 * int'(d) + 16) @(posedge pclk);
  endtask : run

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------
  // result watcher and pulse counters
  // ---------------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
    if (frame_start === 1'b1) begin
      n_frm++;
      last_id = frame_id;
    end
    if (channel_tx_interrupt === 1'b1) n_irq++;
    if (hist_store === 1'b1) begin
      n_hist++;
      last_lbl = hist_label;
    end
    if (pready === 1'b1 && psel && penable && !pwrite) begin
      e = expq.pop_front();
      `CHK("read", e, {pslverr, prdata})
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mode, dly} = '0;
    {mismatches, samples_checked, cycles, n_frm, n_irq, n_hist} = '0;
    lfsr_q = 32'h3C49EF83;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ca(5), 33'h0);
    rd(sa(63), 33'h0);
    rd(12'hFFC, 33'h1_0000_0000);
    apb(1'b1, ctb_pkg::OFS_CHCTL, 32'h1);
    apb(1'b1, ctb_pkg::OFS_HIST, 32'h3);
    apb(1'b1, ctb_pkg::OFS_IEN_LO, 32'h0000_0400);
    // single attempt against arbitration loss, then bus error
    for (int m = 1; m < 3; m++) begin
      load(m, 1'b1);
      run(m, 32'h5, 2'(m), 5'h3);
      `CHK("frames", m, n_frm)
      `CHK("irq", m, n_irq)
      rd(sa(m), 33'h1);
    end
    load(10, 1'b1);
    run(10, 32'h5, 2'h0, 5'h3);
    `CHK("id", id_w[28:0], last_id)
    `CHK("hist", 1, n_hist)
    `CHK("label", lbl_w, last_lbl)
    `CHK("fbuf", {6'h0A, 1'b1}, {frame_buf, frame_single})
    `CHK("fdata", {~lfsr_q, lfsr_q}, {frame_data1, frame_data0})
    `CHK("hbuf", 6'h0A, hist_buf)
    `CHK("irq", 3, n_irq)
    rd(sa(10), 33'h2);
    apb(1'b1, sa(10), 32'h1);
    rd(sa(10), 33'h2);
    apb(1'b1, sa(10), 32'h0);
    rd(sa(10), 33'h0);
    // abort lands while the frame is still on the wire
    load(11, 1'b0);
    mode <= 2'h0;
    dly  <= 5'd20;
    apb(1'b1, ca(11), 32'h5);
    apb(1'b1, ca(11), 32'h7);
    repeat (35) @(posedge pclk);
    `CHK("irq", 3, n_irq)
    rd(sa(11), 33'h3);
    `CHK("hist", 1, n_hist)
    // normal mode resends after a lost arbitration
    load(12, 1'b1);
    run(12, 32'h1, 2'h3, 5'h3);
    `CHK("frames", 6, n_frm)
    `CHK("irq", 3, n_irq)
    `CHK("hist", 2, n_hist)
    rd(sa(12), 33'h2);
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : tb
`default_nettype wire
